// *** mog_pkg.sv ***
// shared constants and types for the monitor output generator
package mog_pkg;
    // quantity width and source codes of the three selectors
    localparam int QW = 16;
    typedef enum logic [2:0] {
        SRC_OUT_FREQ = 3'h0,
        SRC_OUT_CURRENT = 3'h1,
        SRC_OUT_TORQUE = 3'h2,
        SRC_FM_FREQ = 3'h3,
        SRC_OUT_VOLTAGE = 3'h4,
        SRC_IN_POWER = 3'h5,
        SRC_THERMAL = 3'h6,
        SRC_RAMPED_FREQ = 3'h7
    } mog_src_t;
    // full scale values, percentages in units of 0.1 %
    localparam logic [QW-1:0] FS_200_PCT = 16'h07d0;
    localparam logic [QW-1:0] FS_100_PCT = 16'h03e8;
    // control methods that make torque meaningful
    localparam logic [2:0] CTRL_SLV = 3'h3;
    localparam logic [2:0] CTRL_SLV_0HZ = 3'h4;
    localparam logic [2:0] CTRL_FB_VECTOR = 3'h5;
    // reset values of the settings
    localparam mog_src_t DEF_SEL = SRC_OUT_FREQ;
    localparam logic [7:0] DEF_PULSE_GAIN = 8'h80;
    localparam logic [7:0] DEF_VOLT_GAIN = 8'hb4;
    localparam logic [7:0] DEF_CUR_GAIN = 8'h50;
    localparam logic [7:0] DEF_OFFSET = 8'h00;
    // gain of 2**GAIN_SHIFT is unity
    localparam int GAIN_SHIFT = 7;
    // duty period: PWM_LAST_STEP + 1 steps of PWM_STEP_NS each
    localparam logic [7:0] PWM_LAST_STEP = 8'hfe;
    localparam int CLK_PERIOD_NS = 100;
    localparam int PWM_STEP_NS = 1600;
    localparam int PWM_STEP_CYC = (PWM_STEP_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    // current loop: 4 mA of 20 mA on a 255 code scale, span to full
    localparam logic [7:0] CUR_ZERO_CODE = 8'h33;
    localparam logic [7:0] CUR_SPAN_CODE = 8'hcc;
    // scaler division steps
    localparam logic [3:0] DIV_STEPS = 4'h8;
endpackage

// *** mog_scale_if.sv ***
// request and answer bundle between the top and one scaler
`timescale 1ns/100ps
`default_nettype none
interface mog_scale_if;
    logic start;
    logic [15:0] value;
    logic [15:0] full_scale;
    logic [7:0] gain;
    logic [7:0] offset;
    logic bypass_gain;
    logic done;
    logic [7:0] result;
    modport client (output start, value, full_scale, gain, offset,
                    bypass_gain, input done, result);
    modport engine (input start, value, full_scale, gain, offset,
                    bypass_gain, output done, result);
endinterface
`default_nettype wire

// *** mog_scaler.sv ***
// sequential ratio, gain and offset scaler for one monitor channel
`timescale 1ns/100ps
`default_nettype none
module mog_scaler
    import mog_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, active low
    mog_scale_if.engine sif // request and answer
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV = 2'b01,
        ST_MUL = 2'b10
    } mog_sc_state_t;

    mog_sc_state_t state, next_state;
    logic [16:0] rem, next_rem;
    logic [7:0] quot, next_quot;
    logic [3:0] cnt, next_cnt;
    logic [7:0] result, next_result;
    logic done, next_done;

    ////////////////////////////////////////////////////////////////////////
    // restoring divide gives value/full_scale in 1/256, then gain, offset
    always_comb begin
        logic [16:0] shifted;
        logic [15:0] prod;
        logic [7:0] scaled;
        logic [8:0] sum;
        shifted = {rem[15:0], 1'b0};
        prod = 16'(quot * sif.gain);
        scaled = prod[15] ? 8'hff : prod[14:7];
        sum = {1'b0, sif.bypass_gain ? quot : scaled} + {1'b0, sif.offset};
        next_state = state;
        next_rem = rem;
        next_quot = quot;
        next_cnt = cnt;
        next_result = result;
        next_done = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (sif.start) begin
                    next_rem = {1'b0, sif.value};
                    next_quot = 8'h00;
                    next_cnt = DIV_STEPS;
                    if (sif.full_scale == 16'h0000) begin
                        next_state = ST_MUL;
                    end else if (sif.value >= sif.full_scale) begin
                        // saturate at full scale, no division needed
                        next_quot = 8'hff;
                        next_state = ST_MUL;
                    end else begin
                        next_state = ST_DIV;
                    end
                end
            end
            ST_DIV: begin
                if (shifted >= {1'b0, sif.full_scale}) begin
                    next_rem = shifted - {1'b0, sif.full_scale};
                    next_quot = {quot[6:0], 1'b1};
                end else begin
                    next_rem = shifted;
                    next_quot = {quot[6:0], 1'b0};
                end
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_state = ST_MUL;
                end
            end
            ST_MUL: begin
                // fm mode skips the gain stage entirely
                next_result = sum[8] ? 8'hff : sum[7:0];
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            rem <= 17'h00000;
            quot <= 8'h00;
            cnt <= 4'h0;
            result <= 8'h00;
            done <= 1'b0;
        end else begin
            state <= next_state;
            rem <= next_rem;
            quot <= next_quot;
            cnt <= next_cnt;
            result <= next_result;
            done <= next_done;
        end
    end

    assign sif.done = done;
    assign sif.result = result;

    ////////////////////////////////////////////////////////////////////////
    // a normal division ends with a result ten cycles after its start
    chk_div_latency: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (state == ST_IDLE && sif.start && sif.full_scale != 16'h0000
         && sif.value < sif.full_scale) |-> ##10 done)
        else $error("scaler result late or early");

    // with gain bypassed and no offset the ratio passes unchanged
    chk_bypass_gain: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (state == ST_MUL && sif.bypass_gain && sif.offset == 8'h00)
        |=> result == $past(quot))
        else $error("gain applied in fm mode");
endmodule // mog_scaler
`default_nettype wire

// *** mog_top.sv ***
// monitor output generator: duty or fm pulse pin and two analog levels
`timescale 1ns/100ps
`default_nettype none
module mog_top
    import mog_pkg::*;
#(
    parameter int FM_ACC_W = 16 // fm phase accumulator width
) (
    input wire logic sys_clk, // system clock, 10 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic cfg_load, // pulse: take the source, gain and offset settings below
    input wire logic [2:0] pulse_out_source_sel, // pulse pin source
    input wire logic [7:0] pulse_out_gain, // pulse duty gain
    input wire logic [2:0] voltage_out_source_sel, // voltage out source
    input wire logic [7:0] voltage_out_gain, // voltage out gain
    input wire logic [7:0] voltage_out_offset, // voltage out offset
    input wire logic [2:0] current_out_source_sel, // current out source
    input wire logic [7:0] current_out_gain, // current out gain
    input wire logic [7:0] current_out_offset, // current out offset
    input wire logic [15:0] max_frequency_setting, // frequency full scale
    input wire logic [2:0] control_method, // active control method
    input wire logic calibrate_full_scale, // force pulse ratio to full
    input wire logic [15:0] out_freq, // output frequency
    input wire logic [15:0] out_current, // output current, 0.1 %
    input wire logic [15:0] out_torque, // output torque, 0.1 %
    input wire logic [15:0] out_voltage, // output voltage, 0.1 %
    input wire logic [15:0] in_power, // input power, 0.1 %
    input wire logic [15:0] thermal_load, // thermal load, 0.1 %
    input wire logic [15:0] ramped_frequency, // ramp output frequency
    output logic monitor_pulse_pin, // duty or fm pulse output
    output logic [7:0] voltage_monitor_out, // 0-10 V dac code
    output logic [7:0] current_monitor_out, // 4-20 mA dac code
    output logic torque_valid // torque quantity is meaningful
);
    localparam logic [7:0] STEP_LAST = 8'(PWM_STEP_CYC - 1);
    // settle time for a gated torque reading to reach the voltage pin
    localparam logic [4:0] TORQUE_SETTLE = 5'h18;

    logic [2:0] cfg_sel [3];
    logic [2:0] next_cfg_sel [3];
    logic [7:0] cfg_gain [3];
    logic [7:0] next_cfg_gain [3];
    logic [7:0] cfg_off [3];
    logic [7:0] next_cfg_off [3];
    logic [7:0] chan_val [3];
    logic [7:0] next_chan_val [3];
    logic [7:0] s_result [3];
    logic s_done [3];
    logic torque_ok;
    logic fm_mode;
    logic [7:0] pre_cnt, next_pre_cnt;
    logic [7:0] pwm_cnt, next_pwm_cnt;
    logic [7:0] duty, next_duty;
    logic [FM_ACC_W-1:0] acc, next_acc;
    logic next_pin;
    logic [7:0] next_cur_out;
    logic [15:0] cur_prod;
    logic [4:0] torque_off_cnt, next_torque_off_cnt;

    assign torque_ok = control_method == CTRL_SLV
                       || control_method == CTRL_SLV_0HZ
                       || control_method == CTRL_FB_VECTOR;
    assign fm_mode = cfg_sel[0] == SRC_FM_FREQ;

    ////////////////////////////////////////////////////////////////////////
    // quantity and full scale for a selector code; fm only on the pin
    function automatic logic [31:0] pick(input logic [2:0] sel,
                                         input logic allow_fm);
        logic [15:0] v;
        logic [15:0] fs;
        v = 16'h0000;
        fs = FS_100_PCT;
        unique case (sel)
            SRC_OUT_FREQ: begin
                v = out_freq;
                fs = max_frequency_setting;
            end
            SRC_OUT_CURRENT: begin
                v = out_current;
                fs = FS_200_PCT;
            end
            SRC_OUT_TORQUE: begin
                // torque reads zero outside vector control
                v = torque_ok ? out_torque : 16'h0000;
                fs = FS_200_PCT;
            end
            SRC_FM_FREQ: begin
                v = allow_fm ? out_freq : 16'h0000;
                fs = max_frequency_setting;
            end
            SRC_OUT_VOLTAGE: begin
                v = out_voltage;
            end
            SRC_IN_POWER: begin
                v = in_power;
                fs = FS_200_PCT;
            end
            SRC_THERMAL: begin
                v = thermal_load;
            end
            SRC_RAMPED_FREQ: begin
                v = ramped_frequency;
                fs = max_frequency_setting;
            end
        endcase
        return {v, fs};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one scaler per channel, restarted whenever it goes idle
    for (genvar i = 0; i < 3; i++) begin : g_chan
        mog_scale_if sif ();
        logic [31:0] sel_q;
        // a plain assign would miss the live quantities read inside pick
        always_comb sel_q = pick(cfg_sel[i], i == 0);
        assign sif.start = 1'b1;
        // calibration asks for ratio 1/1 so gain sets the meter swing
        assign sif.value = (i == 0 && calibrate_full_scale) ? 16'h0001
                           : sel_q[31:16];
        assign sif.full_scale = (i == 0 && calibrate_full_scale) ? 16'h0001
                                : sel_q[15:0];
        assign sif.gain = cfg_gain[i];
        assign sif.offset = (i == 0) ? 8'h00 : cfg_off[i];
        assign sif.bypass_gain = (i == 0) && fm_mode;
        assign s_done[i] = sif.done;
        assign s_result[i] = sif.result;
        mog_scaler u_scaler (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .sif(sif)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // settings are taken together on cfg_load, defaults from reset
    always_comb begin
        next_cfg_sel = cfg_sel;
        next_cfg_gain = cfg_gain;
        next_cfg_off = cfg_off;
        if (cfg_load) begin
            next_cfg_sel[0] = pulse_out_source_sel;
            next_cfg_sel[1] = voltage_out_source_sel;
            next_cfg_sel[2] = current_out_source_sel;
            next_cfg_gain[0] = pulse_out_gain;
            next_cfg_gain[1] = voltage_out_gain;
            next_cfg_gain[2] = current_out_gain;
            next_cfg_off[1] = voltage_out_offset;
            next_cfg_off[2] = current_out_offset;
        end
    end

    // setting registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_sel <= '{DEF_SEL, DEF_SEL, DEF_SEL};
            cfg_gain <= '{DEF_PULSE_GAIN, DEF_VOLT_GAIN, DEF_CUR_GAIN};
            cfg_off <= '{DEF_OFFSET, DEF_OFFSET, DEF_OFFSET};
        end else begin
            cfg_sel <= next_cfg_sel;
            cfg_gain <= next_cfg_gain;
            cfg_off <= next_cfg_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step prescaler, duty counter, fm accumulator and output stages
    assign cur_prod = 16'(chan_val[2] * CUR_SPAN_CODE);
    always_comb begin
        next_chan_val = chan_val;
        for (int i = 0; i < 3; i++) begin
            if (s_done[i]) begin
                next_chan_val[i] = s_result[i];
            end
        end
        next_pre_cnt = (pre_cnt == STEP_LAST) ? 8'h00 : pre_cnt + 8'h01;
        next_pwm_cnt = pwm_cnt;
        next_duty = duty;
        if (pre_cnt == STEP_LAST) begin
            next_pwm_cnt = (pwm_cnt == PWM_LAST_STEP) ? 8'h00
                           : pwm_cnt + 8'h01;
            // new duty only at the period edge, no mid-period glitch
            if (pwm_cnt == PWM_LAST_STEP) begin
                next_duty = chan_val[0];
            end
        end
        // ratio drives phase step, so pin frequency tracks output freq
        next_acc = acc + FM_ACC_W'(chan_val[0]);
        if (fm_mode) begin
            next_pin = acc[FM_ACC_W-1];
        end else begin
            // duty 255 never drops since pwm_cnt wraps after 254
            next_pin = pwm_cnt < duty;
        end
        // 4 mA floor plus span, never below the live zero
        next_cur_out = CUR_ZERO_CODE + cur_prod[15:8];
        // cycles the voltage channel has shown gated torque, saturating
        next_torque_off_cnt = 5'h00;
        if (cfg_sel[1] == SRC_OUT_TORQUE && cfg_off[1] == 8'h00
            && !torque_ok) begin
            next_torque_off_cnt = (torque_off_cnt == TORQUE_SETTLE)
                                  ? TORQUE_SETTLE : torque_off_cnt + 5'h01;
        end
    end

    // output and counter registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_val <= '{8'h00, 8'h00, 8'h00};
            pre_cnt <= 8'h00;
            pwm_cnt <= 8'h00;
            duty <= 8'h00;
            acc <= '0;
            monitor_pulse_pin <= 1'b0;
            voltage_monitor_out <= 8'h00;
            current_monitor_out <= CUR_ZERO_CODE;
            torque_valid <= 1'b0;
            torque_off_cnt <= 5'h00;
        end else begin
            chan_val <= next_chan_val;
            pre_cnt <= next_pre_cnt;
            pwm_cnt <= next_pwm_cnt;
            duty <= next_duty;
            acc <= next_acc;
            monitor_pulse_pin <= next_pin;
            voltage_monitor_out <= chan_val[1];
            current_monitor_out <= next_cur_out;
            torque_valid <= torque_ok;
            torque_off_cnt <= next_torque_off_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_duty_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !(pre_cnt == STEP_LAST && pwm_cnt == PWM_LAST_STEP)
        |=> $stable(duty))
        else $error("duty changed inside a period");

    chk_duty_level: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!fm_mode) |=> monitor_pulse_pin == ($past(pwm_cnt) < $past(duty)))
        else $error("pulse pin does not follow duty");

    chk_full_high: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!fm_mode && duty == 8'hff) [*2] |=> monitor_pulse_pin)
        else $error("full scale pulse pin not high");

    chk_fm_square: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        fm_mode |=> monitor_pulse_pin == $past(acc[FM_ACC_W-1]))
        else $error("fm pin does not follow accumulator");

    chk_cur_floor: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        current_monitor_out >= CUR_ZERO_CODE)
        else $error("current output below live zero");

    chk_cfg_load: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cfg_load |=> cfg_gain[1] == $past(voltage_out_gain)
                     && cfg_off[2] == $past(current_out_offset))
        else $error("settings not taken on load");

    chk_torque_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        torque_off_cnt == TORQUE_SETTLE |-> voltage_monitor_out == 8'h00)
        else $error("torque shown outside vector control");
endmodule // mog_top
`default_nettype wire

// *** mog_meter_model.sv ***
// moving-coil meter stand-in that integrates the pulse pin over a window
`timescale 1ns/100ps
`default_nettype none
module mog_meter_model #(
    parameter int WIN = 4080 // integration window in clock cycles
) (
    input wire logic sys_clk, // system clock
    input wire logic pin, // monitored pulse pin
    input wire logic start, // pulse: open one window
    output int high_cnt, // cycles seen high
    output int rise_cnt, // rising edges seen
    output logic done // window closed
);
    int left;
    logic last;
    ////////////////////////////////////////////////////////////////////////
    // one whole duty period read at any phase gives the same on-time,
    // so no alignment with the generator's period counter is needed
    always @(posedge sys_clk) begin
        last <= pin;
        if (start) begin
            high_cnt <= 0;
            rise_cnt <= 0;
            left <= WIN;
            done <= 1'b0;
        end else if (left > 0) begin
            high_cnt <= high_cnt + ((pin === 1'b1) ? 1 : 0);
            rise_cnt <= rise_cnt + ((pin === 1'b1 && last === 1'b0) ? 1 : 0);
            left <= left - 1;
            done <= (left == 1);
        end
    end
endmodule // mog_meter_model
`default_nettype wire

// *** monitor_output_generator_bench.sv ***
// self-checking bench for the monitor output generator
`timescale 1ns/100ps
`default_nettype none
module monitor_output_generator_bench
    import mog_pkg::*;
;
    localparam int WIN = (int'(PWM_LAST_STEP) + 1) * PWM_STEP_CYC;
    localparam logic [2:0] PSEL [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h5};
    localparam logic [7:0] PGAIN [6] = '{8'h80, 8'hff, 8'hc8, 8'h00, 8'h5a,
                                         8'hff};
    logic sys_clk, rst_n, cfg_load, cal, pin, tv, meas_start, meas_done;
    logic [2:0] ps, vs, cs, ctl;
    logic [7:0] pg, vg, vo, cg, co, vout, cout;
    logic [15:0] maxf;
    logic [15:0] q [8];
    int high_cnt, rise_cnt, error_cnt, checks, duty;
    int m_ps = DEF_SEL, m_vs = DEF_SEL, m_cs = DEF_SEL, m_vo = DEF_OFFSET;
    int m_pg = DEF_PULSE_GAIN, m_vg = DEF_VOLT_GAIN, m_cg = DEF_CUR_GAIN;
    int m_co = DEF_OFFSET;
    ////////////////////////////////////////////////////////////////////////
    // clock, design and meter; fm accumulator shortened to keep runs brief
    always #50 sys_clk = ~sys_clk;
    mog_top #(.FM_ACC_W(8)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .cfg_load(cfg_load), .pulse_out_source_sel(ps), .pulse_out_gain(pg),
        .voltage_out_source_sel(vs), .voltage_out_gain(vg),
        .voltage_out_offset(vo), .current_out_source_sel(cs),
        .current_out_gain(cg), .current_out_offset(co),
        .max_frequency_setting(maxf), .control_method(ctl),
        .calibrate_full_scale(cal), .out_freq(q[0]), .out_current(q[1]),
        .out_torque(q[2]), .out_voltage(q[4]), .in_power(q[5]),
        .thermal_load(q[6]), .ramped_frequency(q[7]),
        .monitor_pulse_pin(pin), .voltage_monitor_out(vout),
        .current_monitor_out(cout), .torque_valid(tv));
    mog_meter_model #(.WIN(WIN)) meter (.sys_clk(sys_clk), .pin(pin),
        .start(meas_start), .high_cnt(high_cnt), .rise_cnt(rise_cnt),
        .done(meas_done));
    ////////////////////////////////////////////////////////////////////////
    // reference model: quantity to 0..255 ratio, then gain and offset
    function automatic int ratio(int sel, bit analog);
        int v;
        int fs;
        if (analog && sel == 3) return 0;
        v = (sel == 3) ? int'(q[0]) : int'(q[sel]);
        case (sel)
            0, 3, 7: fs = int'(maxf);
            1, 2, 5: fs = int'(FS_200_PCT);
            default: fs = int'(FS_100_PCT);
        endcase
        if (sel == 2 && !(ctl inside {CTRL_SLV, CTRL_SLV_0HZ, CTRL_FB_VECTOR}))
            v = 0;
        if (fs == 0) return 0;
        return (v * 256 / fs > 255) ? 255 : v * 256 / fs;
    endfunction
    function automatic int gsc(int r, int g, int o);
        int s;
        s = (r * g) >> GAIN_SHIFT;
        s = (s > 255 ? 255 : s) + o;
        return s > 255 ? 255 : s;
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // closing report and comparisons
    task automatic complete_run();
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic cmp_cnt(input int got, input int exp, input int tol);
        checks++;
        if (got > exp + tol || got < exp - tol) begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // drivers: inputs move 10 ns after the rising edge
    task automatic step(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #10;
        end
    endtask
    task automatic load();
        cfg_load = 1'b1;
        m_ps = ps;
        m_pg = pg;
        m_vs = vs;
        m_vg = vg;
        m_vo = vo;
        m_cs = cs;
        m_cg = cg;
        m_co = co;
        step(1);
        cfg_load = 1'b0;
    endtask
    task automatic rand_all();
        for (int i = 0; i < 8; i++) q[i] = 16'($urandom_range(2300));
        vg = 8'($urandom_range(255));
        vo = 8'($urandom_range(80));
        cg = 8'($urandom_range(255));
        co = 8'($urandom_range(80));
    endtask
    // the meter window is bounded so a dead pin cannot hang the run
    task automatic measure();
        int n;
        meas_start = 1'b1;
        step(1);
        meas_start = 1'b0;
        n = 0;
        while (meas_done !== 1'b1 && n < WIN + 20) begin
            step(1);
            n++;
        end
        if (meas_done !== 1'b1) begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, 1'b0, 1'b1);
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic check_analog();
        cmp8(vout, 8'(gsc(ratio(m_vs, 1), m_vg, m_vo)));
        cmp8(cout, 8'(int'(CUR_ZERO_CODE) + ((gsc(ratio(m_cs, 1), m_cg,
            m_co) * int'(CUR_SPAN_CODE)) >> 8)));
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        cfg_load = 1'b0;
        meas_start = 1'b0;
        cal = 1'b0;
        ctl = 3'h0;
        error_cnt = 0;
        checks = 0;
        maxf = 16'h1770;
        void'($urandom(32'hde53));
        rand_all();
        ps = 3'h5;
        pg = 8'h11;
        vs = 3'h6;
        cs = 3'h1;
        step(1);
        cmp8(vout, 8'h00);
        cmp8(cout, CUR_ZERO_CODE);
        cmp_bit(pin, 1'b0);
        cmp_bit(tv, 1'b0);
        step(1);
        rst_n = 1'b1;
        // settings not loaded yet: defaults must be in use
        step(40);
        check_analog();
        // every code on both analog channels, torque with and without vector
        for (int i = 0; i < 16; i++) begin
            rand_all();
            vs = 3'(i);
            cs = 3'(i + 3);
            ctl = 3'($urandom_range(7));
            // one pass with torque gated and no offset on the voltage side
            if (i == 2) begin
                vo = 8'h00;
                ctl = 3'h1;
            end
            load();
            step(40);
            check_analog();
        end
        for (int i = 0; i < 8; i++) begin
            ctl = 3'(i);
            step(2);
            cmp_bit(tv, 1'(i >= 3 && i <= 5));
        end
        // duty output: gain boundaries and calibration in the last case
        for (int i = 0; i < 6; i++) begin
            ps = PSEL[i];
            pg = PGAIN[i];
            cal = (i == 5);
            load();
            step(4300);
            measure();
            duty = gsc(cal ? 255 : ratio(m_ps, 0), m_pg, 0);
            cmp_cnt(high_cnt, duty * PWM_STEP_CYC, 0);
            cmp_cnt(rise_cnt, (duty > 0 && duty < 255) ? 1 : 0, 0);
        end
        // fm output: edge rate follows frequency, gain has no effect
        ps = SRC_FM_FREQ;
        cal = 1'b0;
        for (int i = 0; i < 2; i++) begin
            q[0] = (i == 0) ? 16'h05dc : 16'h02ee;
            pg = (i == 0) ? 8'h00 : 8'hff;
            load();
            step(40);
            measure();
            cmp_cnt(rise_cnt, WIN * ratio(3, 0) / 256, 2);
        end
        complete_run();
    end
endmodule // monitor_output_generator_bench
`default_nettype wire
